//--- hw/pam_defines.svh
// constants of the alarm monitor
`ifndef PAM_DEFINES_SVH
`define PAM_DEFINES_SVH
// ===========================================================================
// register byte offsets
`define PAM_OFF_CTRL 8'h00
`define PAM_OFF_LO 8'h04
`define PAM_OFF_HI 8'h08
`define PAM_OFF_HYST 8'h0C
`define PAM_OFF_SP 8'h10
`define PAM_OFF_OLTIME 8'h14
`define PAM_OFF_OLDEV 8'h18
`define PAM_OFF_LOCK 8'h1C
`define PAM_OFF_CMD 8'h20
`define PAM_OFF_STAT 8'h24
`define PAM_OFF_CUR 8'h28
`define PAM_OFF_FAULT 8'h2C
// ===========================================================================
// control register bit positions
`define PAM_CTRL_LATCH 0
`define PAM_CTRL_SIL 1
`define PAM_CTRL_BLOCK 2
`define PAM_CTRL_DEV 3
`define PAM_CTRL_OLEN 4
`define PAM_CTRL_CURSRC 5
`define PAM_CTRL_PWD 6
`define PAM_CTRL_KLVL 7
`define PAM_CTRL_FN_LO 8
`define PAM_CTRL_FN_HI 9
`define PAM_CTRL_PROF 10
// lock register fields: read lock [2:0], write lock [6:4], lock level [10:8]
`define PAM_LOCK_RD_LO 0
`define PAM_LOCK_WR_LO 4
`define PAM_LOCK_LV_LO 8
// command register bits, write one to act
`define PAM_CMD_CLEAR 0
`define PAM_CMD_SILENCE 1
`define PAM_CMD_RESTART 2
// ===========================================================================
// reset values
`define PAM_CTRL_RST 16'h0000
`define PAM_HYST_RST 16'h0001
`define PAM_HI_RST 16'h7FFF
`define PAM_LO_RST 16'h8000
`define PAM_OLTIME_RST 16'h0064
`define PAM_OLDEV_RST 16'h000A
`define PAM_RDLOCK_RST 3'h5
`define PAM_WRLOCK_RST 3'h5
`define PAM_LVL_RST 3'h1
// ===========================================================================
// limits and timing
`define PAM_CUR_MIN 16'h00C8
`define PAM_PWR_FULL 8'h64
`define PAM_LOCK_MAX 3'h5
`define PAM_CLK_HZ 50000000
`define PAM_DISP_MS 500
`endif

//--- hw/pam_pkg.sv
// shared types of the alarm monitor
package pam_pkg;
  // ===========================================================================
  // apb request bundle from the bus master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pam_apb_req_t;
  // open-loop supervisor states
  typedef enum logic {OL_IDLE, OL_WATCH} pam_ol_state_t;
  // load current fault codes
  typedef enum logic [1:0] {FLT_NONE, FLT_OPEN, FLT_SHORT} pam_fault_t;
endpackage : pam_pkg

//--- hw/pam_thresh.sv
// threshold window with hysteresis zone
`timescale 1ns/100ps
module pam_thresh (
  input wire logic [15:0] value_i,  // signed sample
  input wire logic [15:0] low_i,    // signed low threshold
  input wire logic [15:0] high_i,   // signed high threshold
  input wire logic [15:0] hyst_i,   // hysteresis width
  input wire logic low_en_i,        // low side evaluated
  output logic low_hit_o,           // at or below low
  output logic high_hit_o,          // at or above high
  output logic beyond_o,            // either threshold reached
  output logic normal_o             // back inside beyond the zone
);
  // ===========================================================================
  // compare in 17 bits so threshold +/- hysteresis cannot wrap for hysteresis up to 16'h8000
  logic signed [16:0] v;
  logic signed [16:0] lo_h;
  logic signed [16:0] hi_h;
  assign v = {value_i[15], value_i};
  assign lo_h = {low_i[15], low_i} + {1'b0, hyst_i};
  assign hi_h = {high_i[15], high_i} - {1'b0, hyst_i};
  // reaching a threshold counts as alarm
  assign high_hit_o = v >= signed'({high_i[15], high_i});
  assign low_hit_o = low_en_i & (v <= signed'({low_i[15], low_i}));
  assign beyond_o = high_hit_o | low_hit_o;
  // a disabled low side never holds the condition
  assign normal_o = (v < hi_h) & (~low_en_i | (v > lo_h));
endmodule : pam_thresh

//--- hw/pam_top.sv
// process alarm and fault monitor with apb register file
// Behaviour
// R1 - alarm state entered when value reaches high or low threshold
// R2 - condition ends only once value is back past the hysteresis zone
// R3 - latching keeps alarm after condition ends until user clear
// R4 - without latching alarm clears itself when condition ends
// R5 - silence request, if enabled, drops alarm output while state persists
// R6 - silenced output re-arms only after value returns beyond hysteresis
// R7 - blocking suppresses alarm until value first enters normal range
// R8 - deviation blocking re-blocks on set point change until normal
// R9 - current-source low alarm only evaluated at or above 2 mA
// R10 - shorted load: zero power demand while current flows
// R11 - open load: nonzero power demand with no current
// R12 - live current readable, last current and heater faults held
// R13 - open-loop watch starts timer once output reaches 100 percent
// R14 - timer expiry without deviation raises open-loop error
// R15 - open-loop error turns control off and shows indication
// R16 - value moving the wrong way gives reversed-loop indication
// R17 - active message alternates display, clear and silence responses
// R18 - key level toggles per press from a configurable power-up level; code loads bit 7 one cycle after reset, before any write, so it starts low
// R19 - low power-up level with profile function starts profile at once
// R20 - key function instance selects one of four profiles
// R21 - read lock 1 to 5, write lock 0 to 5, higher grants more
// R22 - password security restricts access by lock level 1 to 5
// R23 - deviation thresholds are set point plus offsets
// R24 - process alarms use absolute thresholds
// R25 - conditions evaluated per sample strobe, state cleared on reset
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "pam_defines.svh"
module pam_top #(
  parameter int DISP_CYC = (`PAM_CLK_HZ / 1000) * `PAM_DISP_MS
) (
  input wire logic clock_i,                   // 50 MHz clock
  input wire logic rst_i,                     // synchronous reset, high
  input wire logic ce_i,                      // clock enable, freezes all
  input wire pam_pkg::pam_apb_req_t apb_i,    // apb request
  output logic [31:0] prdata_o,               // apb read data
  output logic pready_o,                      // apb ready
  output logic pslverr_o,                     // apb error, unmapped
  input wire logic sample_valid_i,            // new sample strobe
  input wire logic [15:0] process_value_i,    // signed process value
  input wire logic [15:0] load_current_i,     // load current, 10 uA units
  input wire logic [7:0] power_demand_i,      // power demand, percent
  input wire logic key_pin_i,                 // programmable key, async
  output logic alarm_o,                       // alarm output
  output logic alarm_state_o,                 // alarm state
  output logic control_on_o,                  // control mode on
  output logic open_loop_o,                   // open-loop indication
  output logic reversed_loop_o,               // reversed-loop indication
  output logic load_current_fault_o,          // live current fault
  output logic display_alt_o,                 // show message, else value
  output logic key_level_o,                   // current key level
  output logic profile_run_o,                 // selected profile running
  output logic [1:0] key_function_select_o,   // profile instance
  output logic password_enable_o,             // password security on
  output logic [2:0] read_lock_o,             // read lock level
  output logic [2:0] write_lock_level_o,      // write lock level
  output logic [2:0] access_level_o           // effective access level
);
  // ===========================================================================
  // registers
  logic [15:0] ctrl_r, lo_r, hi_r, hyst_r, sp_r, oltime_r, oldev_r;
  logic [2:0] rlock_r, wlock_r, lvl_r;
  logic [31:0] prdata_r, rd_nxt;
  logic err_r, hit_nxt, setup, wr, wr_cmd, smp;
  // alarm state
  logic alarm_r, cond_r, armed_r, silenced_r, clr_pend_r, sil_pend_r, blocked, beyond, normal;
  // faults and current
  logic [15:0] cur_r;
  logic lcf_r, cur_det;
  logic [1:0] cur_code_r, htr_code_r;
  pam_pkg::pam_fault_t fault_now;
  // open loop
  pam_pkg::pam_ol_state_t ol_state_r;
  logic [15:0] ol_cnt_r, ol_base_r;
  logic ol_err_r, rev_err_r, ctl_on_r;
  logic signed [16:0] rise;
  // display and key
  logic [31:0] disp_cnt_r;
  logic [2:0] ksh_r;
  logic disp_r, msg, key_r, init_r;
  // thresholds
  logic [15:0] thr_lo, thr_hi;
  logic pv_beyond, pv_normal, cur_beyond, cur_normal, cur_lo_hit, cur_hi_hit;

  // ===========================================================================
  // apb slave: decode in setup, answer in the first access cycle
  assign setup = apb_i.psel & ~apb_i.penable;
  assign wr = ce_i & apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign wr_cmd = wr & (apb_i.paddr == `PAM_OFF_CMD);
  assign smp = ce_i & sample_valid_i;
  // ready follows the enable so a frozen block holds the master
  assign pready_o = ce_i;
  assign pslverr_o = apb_i.psel & apb_i.penable & err_r;
  assign prdata_o = prdata_r;

  // clamp a lock field into its legal range
  function automatic logic [2:0] clamp(input logic [2:0] v, input logic [2:0] lo);
    clamp = (v < lo) ? lo : ((v > `PAM_LOCK_MAX) ? `PAM_LOCK_MAX : v);
  endfunction : clamp

  // read multiplexer, unmapped reads return zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (apb_i.paddr)
      `PAM_OFF_CTRL: rd_nxt = {16'h0000, ctrl_r};
      `PAM_OFF_LO: rd_nxt = {16'h0000, lo_r};
      `PAM_OFF_HI: rd_nxt = {16'h0000, hi_r};
      `PAM_OFF_HYST: rd_nxt = {16'h0000, hyst_r};
      `PAM_OFF_SP: rd_nxt = {16'h0000, sp_r};
      `PAM_OFF_OLTIME: rd_nxt = {16'h0000, oltime_r};
      `PAM_OFF_OLDEV: rd_nxt = {16'h0000, oldev_r};
      `PAM_OFF_LOCK: rd_nxt = {21'h000000, lvl_r, 1'b0, wlock_r, 1'b0, rlock_r};
      `PAM_OFF_CMD: rd_nxt = 32'h0000_0000;
      `PAM_OFF_STAT: rd_nxt = {21'h000000, disp_r, key_r, ctl_on_r, rev_err_r,
                               ol_err_r, lcf_r, blocked, silenced_r, cond_r,
                               alarm_o, alarm_r};
      `PAM_OFF_CUR: rd_nxt = {16'h0000, cur_r}; // R12
      `PAM_OFF_FAULT: rd_nxt = {26'h0000000, htr_code_r, 2'h0, cur_code_r}; // R12
      default: hit_nxt = 1'b0;
    endcase
  end

  // read data and error latched at the setup cycle
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
    else if (ce_i && setup)
    begin
      prdata_r <= apb_i.pwrite ? 32'h0000_0000 : rd_nxt;
      err_r <= ~hit_nxt;
    end
  end

  // configuration writes
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `PAM_CTRL_RST;
      lo_r <= `PAM_LO_RST;
      hi_r <= `PAM_HI_RST;
      hyst_r <= `PAM_HYST_RST;
      sp_r <= 16'h0000;
      oltime_r <= `PAM_OLTIME_RST;
      oldev_r <= `PAM_OLDEV_RST;
      rlock_r <= `PAM_RDLOCK_RST;
      wlock_r <= `PAM_WRLOCK_RST;
      lvl_r <= `PAM_LVL_RST;
    end
    else if (wr)
    begin
      case (apb_i.paddr)
        `PAM_OFF_CTRL: ctrl_r <= apb_i.pwdata[15:0];
        `PAM_OFF_LO: lo_r <= apb_i.pwdata[15:0];
        `PAM_OFF_HI: hi_r <= apb_i.pwdata[15:0];
        `PAM_OFF_HYST: hyst_r <= apb_i.pwdata[15:0];
        `PAM_OFF_SP: sp_r <= apb_i.pwdata[15:0];
        `PAM_OFF_OLTIME: oltime_r <= apb_i.pwdata[15:0];
        `PAM_OFF_OLDEV: oldev_r <= apb_i.pwdata[15:0];
        `PAM_OFF_LOCK:
        begin
          rlock_r <= clamp(apb_i.pwdata[`PAM_LOCK_RD_LO +: 3], 3'h1); // R21
          wlock_r <= clamp(apb_i.pwdata[`PAM_LOCK_WR_LO +: 3], 3'h0); // R21
          lvl_r <= clamp(apb_i.pwdata[`PAM_LOCK_LV_LO +: 3], 3'h1); // R22
        end
        default: ;
      endcase
    end
  end

  // ===========================================================================
  // thresholds: offsets from the set point or absolute values
  assign thr_lo = ctrl_r[`PAM_CTRL_DEV] ? 16'(sp_r + lo_r) : lo_r; // R23 R24
  assign thr_hi = ctrl_r[`PAM_CTRL_DEV] ? 16'(sp_r + hi_r) : hi_r; // R23 R24
  assign cur_det = load_current_i >= `PAM_CUR_MIN;

  // process value window
  pam_thresh u_pv (
    .value_i(process_value_i),
    .low_i(thr_lo),
    .high_i(thr_hi),
    .hyst_i(hyst_r),
    .low_en_i(1'b1),
    .low_hit_o(),
    .high_hit_o(),
    .beyond_o(pv_beyond),
    .normal_o(pv_normal)
  );

  // current window, low side only with current flowing
  pam_thresh u_cur (
    .value_i(load_current_i),
    .low_i(lo_r),
    .high_i(hi_r),
    .hyst_i(hyst_r),
    .low_en_i(cur_det), // R9
    .low_hit_o(cur_lo_hit),
    .high_hit_o(cur_hi_hit),
    .beyond_o(cur_beyond),
    .normal_o(cur_normal)
  );

  assign beyond = ctrl_r[`PAM_CTRL_CURSRC] ? cur_beyond : pv_beyond;
  assign normal = ctrl_r[`PAM_CTRL_CURSRC] ? cur_normal : pv_normal;
  assign blocked = ctrl_r[`PAM_CTRL_BLOCK] & ~armed_r;

  // ===========================================================================
  // operator requests wait for the next sample; a new one wins
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      clr_pend_r <= 1'b0;
      sil_pend_r <= 1'b0;
    end
    else
    begin
      if (smp)
      begin
        clr_pend_r <= 1'b0;
        sil_pend_r <= 1'b0;
      end
      if (wr_cmd && apb_i.pwdata[`PAM_CMD_CLEAR])
        clr_pend_r <= 1'b1; // R17
      if (wr_cmd && apb_i.pwdata[`PAM_CMD_SILENCE])
        sil_pend_r <= 1'b1; // R17
    end
  end

  // blocking arm: armed once the value sits in the normal range
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      armed_r <= 1'b0; // R25
    else if (ce_i)
    begin
      if (smp && normal)
        armed_r <= 1'b1; // R7
      // a set point move re-blocks a deviation alarm
      if (wr && apb_i.paddr == `PAM_OFF_SP && ctrl_r[`PAM_CTRL_DEV])
        armed_r <= 1'b0; // R8
    end
  end

  // condition, alarm state and silence, evaluated per sample
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cond_r <= 1'b0; // R25
      alarm_r <= 1'b0;
      silenced_r <= 1'b0;
    end
    else if (smp) // R25
    begin
      if (beyond)
        cond_r <= 1'b1; // R1
      else if (normal)
        cond_r <= 1'b0; // R2
      if (beyond && !blocked)
        alarm_r <= 1'b1; // R1 R7
      else if (!ctrl_r[`PAM_CTRL_LATCH] && normal)
        alarm_r <= 1'b0; // R4
      else if (ctrl_r[`PAM_CTRL_LATCH] && clr_pend_r && !beyond && (normal || !cond_r))
        alarm_r <= 1'b0; // R3
      if (sil_pend_r && ctrl_r[`PAM_CTRL_SIL] && alarm_r)
        silenced_r <= 1'b1; // R5
      else if (normal)
        silenced_r <= 1'b0; // R6
    end
  end

  assign alarm_state_o = alarm_r;
  assign alarm_o = alarm_r & ~silenced_r; // R5

  // ===========================================================================
  // load current faults from demand versus measured current
  always_comb
  begin
    if (power_demand_i == 8'h00 && cur_det)
      fault_now = pam_pkg::FLT_SHORT; // R10
    else if (power_demand_i != 8'h00 && !cur_det)
      fault_now = pam_pkg::FLT_OPEN; // R11
    else
      fault_now = pam_pkg::FLT_NONE;
  end

  // live reading and most recent fault codes
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cur_r <= 16'h0000;
      lcf_r <= 1'b0;
      cur_code_r <= 2'h0;
      htr_code_r <= 2'h0;
    end
    else if (smp)
    begin
      cur_r <= load_current_i; // R12
      lcf_r <= fault_now != pam_pkg::FLT_NONE;
      if (fault_now != pam_pkg::FLT_NONE)
        cur_code_r <= fault_now; // R12
      if (cur_lo_hit)
        htr_code_r <= 2'h1; // R12
      else if (cur_hi_hit)
        htr_code_r <= 2'h2;
    end
  end

  assign load_current_fault_o = lcf_r;

  // ===========================================================================
  // open-loop supervisor; errors set at a sample win over a restart write
  assign rise = 17'(signed'({process_value_i[15], process_value_i})
                - signed'({ol_base_r[15], ol_base_r}));

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ol_state_r <= pam_pkg::OL_IDLE; // R25
      ol_cnt_r <= 16'h0000;
      ol_base_r <= 16'h0000;
      ol_err_r <= 1'b0;
      rev_err_r <= 1'b0;
      ctl_on_r <= 1'b1;
    end
    else if (ce_i)
    begin
      if (wr_cmd && apb_i.pwdata[`PAM_CMD_RESTART])
      begin
        ol_err_r <= 1'b0;
        rev_err_r <= 1'b0;
        ctl_on_r <= 1'b1;
      end
      if (smp)
      begin
        case (ol_state_r)
          pam_pkg::OL_IDLE:
          begin
            if (ctrl_r[`PAM_CTRL_OLEN] && ctl_on_r && power_demand_i >= `PAM_PWR_FULL)
            begin
              ol_state_r <= pam_pkg::OL_WATCH; // R13
              ol_cnt_r <= 16'h0000;
              ol_base_r <= process_value_i;
            end
          end
          pam_pkg::OL_WATCH:
          begin
            if (!ctrl_r[`PAM_CTRL_OLEN] || power_demand_i < `PAM_PWR_FULL)
              ol_state_r <= pam_pkg::OL_IDLE;
            else if (rise >= signed'({1'b0, oldev_r}))
              ol_state_r <= pam_pkg::OL_IDLE;
            else if (-rise >= signed'({1'b0, oldev_r}))
            begin
              ol_state_r <= pam_pkg::OL_IDLE;
              rev_err_r <= 1'b1; // R16
              ctl_on_r <= 1'b0;
            end
            else if (ol_cnt_r + 16'h0001 >= oltime_r)
            begin
              ol_state_r <= pam_pkg::OL_IDLE;
              ol_err_r <= 1'b1; // R14
              ctl_on_r <= 1'b0; // R15
            end
            else
              ol_cnt_r <= ol_cnt_r + 16'h0001; // R13
          end
          default: ol_state_r <= pam_pkg::OL_IDLE;
        endcase
      end
    end
  end

  assign control_on_o = ctl_on_r; // R15
  assign open_loop_o = ol_err_r; // R15
  assign reversed_loop_o = rev_err_r; // R16

  // ===========================================================================
  // message display alternation
  assign msg = alarm_r | ol_err_r | rev_err_r | lcf_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      disp_cnt_r <= 32'h0000_0000;
      disp_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!msg)
      begin
        disp_cnt_r <= 32'h0000_0000;
        disp_r <= 1'b0;
      end
      else if (disp_cnt_r >= 32'(DISP_CYC - 1))
      begin
        disp_cnt_r <= 32'h0000_0000;
        disp_r <= ~disp_r; // R17
      end
      else
        disp_cnt_r <= disp_cnt_r + 32'h0000_0001;
    end
  end

  assign display_alt_o = disp_r;

  // ===========================================================================
  // key pin synchroniser; edge taken from the second and third stage only
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      ksh_r <= 3'h0;
    else if (ce_i)
      ksh_r <= {ksh_r[1:0], key_pin_i};
  end

  // key level: loaded from the power-up setting after reset, then toggled
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      key_r <= 1'b0;
      init_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!init_r)
      begin
        key_r <= ctrl_r[`PAM_CTRL_KLVL]; // R18
        init_r <= 1'b1;
      end
      else if (ksh_r[1] && !ksh_r[2])
        key_r <= ~key_r; // R18
    end
  end

  assign key_level_o = key_r;
  // low level runs the profile, so a low power-up level starts it at once
  assign profile_run_o = init_r & ctrl_r[`PAM_CTRL_PROF] & ~key_r; // R19
  assign key_function_select_o = ctrl_r[`PAM_CTRL_FN_HI:`PAM_CTRL_FN_LO]; // R20

  // ===========================================================================
  // lock levels and effective access
  assign password_enable_o = ctrl_r[`PAM_CTRL_PWD];
  assign read_lock_o = rlock_r; // R21
  assign write_lock_level_o = wlock_r; // R21
  assign access_level_o = ctrl_r[`PAM_CTRL_PWD] ? lvl_r : rlock_r; // R22

endmodule : pam_top

//--- bench/pam_monitor.sv
// concurrent checks on the alarm monitor ports
`timescale 1ns/100ps
module pam_monitor (
  input wire logic clock_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic sample_valid_i, // sample strobe
  input wire logic [15:0] load_current_i, // load current
  input wire logic [7:0] power_demand_i, // demand
  input wire logic alarm_o, // alarm output
  input wire logic alarm_state_o, // alarm state
  input wire logic control_on_o, // control on
  input wire logic open_loop_o, // open-loop flag
  input wire logic load_current_fault_o, // current fault
  input wire logic [2:0] read_lock_o // read lock
);
  // ===========================================================================
  // one clock domain
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // a taken sample
  logic smp_c;
  assign smp_c = sample_valid_i && ce_i;
  AST_RST: assert property ($fell(rst_i) |-> !alarm_state_o && !alarm_o && control_on_o)
    else $error("outputs not at reset values");
  AST_HOLD: assert property (!$past(smp_c) |-> $stable(alarm_state_o))
    else $error("alarm state moved without a sample");
  AST_SIL: assert property (alarm_o |-> alarm_state_o)
    else $error("alarm output without alarm state");
  AST_SHORT: assert property (smp_c && power_demand_i == 8'h00 && load_current_i >= 16'h00C8 |=>
    load_current_fault_o)
    else $error("shorted load not flagged");
  AST_OPEN: assert property (smp_c && power_demand_i != 8'h00 && load_current_i == 16'h0000 |=>
    load_current_fault_o)
    else $error("open load not flagged");
  AST_HEALTHY: assert property (smp_c && power_demand_i != 8'h00 && load_current_i >= 16'h00C8
    |=> !load_current_fault_o)
    else $error("fault flagged on a healthy load");
  AST_OLOFF: assert property (open_loop_o |-> !control_on_o)
    else $error("control still on with open loop");
  AST_LOCK: assert property (read_lock_o inside {[3'h1:3'h5]})
    else $error("read lock out of range");
endmodule : pam_monitor
bind pam_top pam_monitor u_mon (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .sample_valid_i(sample_valid_i),
  .load_current_i(load_current_i),
  .power_demand_i(power_demand_i),
  .alarm_o(alarm_o),
  .alarm_state_o(alarm_state_o),
  .control_on_o(control_on_o),
  .open_loop_o(open_loop_o),
  .load_current_fault_o(load_current_fault_o),
  .read_lock_o(read_lock_o)
);

//--- bench/tb_pam_top.sv
// self-checking testbench of the alarm monitor
`timescale 1ns/100ps
module tb_pam_top;
  logic clock_i, rst_i, sample_valid_i, key_pin_i, er;
  pam_pkg::pam_apb_req_t apb_i;
  logic [15:0] process_value_i, load_current_i, c;
  logic [7:0] power_demand_i, d;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, alarm_o, alarm_state_o, control_on_o, open_loop_o;
  logic load_current_fault_o, key_level_o, profile_run_o;
  logic [2:0] read_lock_o, write_lock_level_o, access_level_o;
  int errors, samples_checked, i;
  // short display period keeps the run brief
  pam_top #(.DISP_CYC(4)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .apb_i(apb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i),
    .process_value_i(process_value_i), .load_current_i(load_current_i),
    .power_demand_i(power_demand_i), .key_pin_i(key_pin_i), .alarm_o(alarm_o),
    .alarm_state_o(alarm_state_o), .control_on_o(control_on_o), .open_loop_o(open_loop_o),
    .reversed_loop_o(), .load_current_fault_o(load_current_fault_o), .display_alt_o(),
    .key_level_o(key_level_o), .profile_run_o(profile_run_o), .key_function_select_o(),
    .password_enable_o(), .read_lock_o(read_lock_o),
    .write_lock_level_o(write_lock_level_o), .access_level_o(access_level_o));
  // ===========================================================================
  // 50 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // verdict
  task automatic end_of_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // apb transfer with bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dat};
    @(posedge clock_i);
    apb_i.penable <= 1'b1;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    apb_i <= '0;
    if (pready_o !== 1'b1)
    begin
      errors++;
      $display("Error at %0t: apb timeout", $time);
      end_of_test();
    end
  endtask : apb
  // one sample, then compare alarm state and output
  task automatic run(input logic [15:0] v, input logic es, input logic eo);
    @(posedge clock_i);
    process_value_i <= v;
    power_demand_i <= d;
    load_current_i <= c;
    sample_valid_i <= 1'b1;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    @(negedge clock_i);
    chk({31'h0, alarm_state_o}, {31'h0, es});
    chk({31'h0, alarm_o}, {31'h0, eo});
  endtask : run
  // register values right after reset
  function automatic logic [31:0] rv(input logic [7:0] a);
    case (a)
      8'h04: return 32'h8000;
      8'h08: return 32'h7FFF;
      8'h0C: return 32'h0001;
      8'h14: return 32'h0064;
      8'h18: return 32'h000A;
      8'h1C: return 32'h0155;
      8'h24: return 32'h0100;
      default: return 32'h0;
    endcase
  endfunction : rv
  // current fault; stimulus keeps current at 0 or at least 2 mA
  function automatic logic fx(input logic [7:0] pd, input logic [15:0] lc);
    return (pd == 8'h00) ? (lc >= 16'h00C8) : (lc == 16'h0000);
  endfunction : fx
  // main sequence
  initial
  begin
    errors = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    apb_i = '0;
    sample_valid_i = 1'b0;
    process_value_i = 16'h0000;
    load_current_i = 16'h0000;
    power_demand_i = 8'h00;
    key_pin_i = 1'b0;
    d = 8'h00;
    c = 16'h0000;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    i = $urandom(43);
    for (i = 0; i < 13; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, rv(8'(i * 4)));
      chk({31'h0, er}, {31'h0, i == 12});
    end
    apb(1'b1, 8'h04, 32'h0000FF9C);
    apb(1'b1, 8'h08, 32'h00000064);
    apb(1'b1, 8'h0C, 32'h0000000A);
    apb(1'b1, 8'h00, 32'h00000004);
    run(16'h00C8, 1'b0, 1'b0);
    run(16'h0000, 1'b0, 1'b0);
    run(16'h00C8, 1'b1, 1'b1);
    run(16'h0000, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h0000000C);
    apb(1'b1, 8'h10, 32'h00000032);
    run(16'h00C8, 1'b0, 1'b0);
    run(16'h0000, 1'b0, 1'b0);
    run(16'h0095, 1'b0, 1'b0);
    run(16'h0096, 1'b1, 1'b1);
    run(16'h0000, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h00000000);
    run(16'h0064, 1'b1, 1'b1);
    run(16'h005A, 1'b1, 1'b1);
    run(16'h0059, 1'b0, 1'b0);
    run(16'hFF9C, 1'b1, 1'b1);
    run(16'hFFA6, 1'b1, 1'b1);
    run(16'hFFA7, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h00000001);
    run(16'h0064, 1'b1, 1'b1);
    run(16'h0000, 1'b1, 1'b1);
    apb(1'b1, 8'h20, 32'h00000001);
    run(16'h0000, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h00000002);
    run(16'h0064, 1'b1, 1'b1);
    apb(1'b1, 8'h20, 32'h00000002);
    run(16'h0064, 1'b1, 1'b0);
    run(16'h005F, 1'b1, 1'b0);
    run(16'h0000, 1'b0, 1'b0);
    run(16'h0064, 1'b1, 1'b1);
    apb(1'b1, 8'h00, 32'h00000000);
    for (i = 0; i < 16; i++)
    begin
      d = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom_range(100, 1));
      c = ($urandom % 2 == 0) ? 16'h0000 : 16'($urandom_range(32767, 200));
      run(16'h0000, 1'b0, 1'b0);
      chk({31'h0, load_current_fault_o}, {31'h0, fx(d, c)});
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, {16'h0, c});
    end
    // flat value at full demand trips open loop
    d = 8'h64;
    c = 16'h012C;
    apb(1'b1, 8'h14, 32'h00000003);
    apb(1'b1, 8'h00, 32'h00000010);
    repeat (5) run(16'h0000, 1'b0, 1'b0);
    chk({31'h0, open_loop_o, control_on_o}, 32'h2);
    apb(1'b1, 8'h1C, 32'h00000352);
    apb(1'b1, 8'h00, 32'h00000440);
    @(negedge clock_i);
    chk({23'h0, read_lock_o, write_lock_level_o, access_level_o}, 32'h0AB);
    chk({30'h0, key_level_o, profile_run_o}, 32'h1);
    @(posedge clock_i);
    key_pin_i <= 1'b1;
    repeat (6) @(negedge clock_i);
    chk({30'h0, key_level_o, profile_run_o}, 32'h2);
    apb(1'b1, 8'h1C, 32'h00000000);
    @(negedge clock_i);
    chk({26'h0, read_lock_o, write_lock_level_o}, 32'h08);
    end_of_test();
  end
endmodule : tb_pam_top
